// *** core/cmr_arbiter.sv ***
`timescale 1ns/10ps
// How it works
// (RULE1) Arrival-order: oldest waiting feeder wins
// (RULE2) After merge clears, next oldest feeder goes
// (RULE3) Centre priority: centre keeps winning when waiting
// (RULE4) Centre idle and clear: sides may release
// (RULE5) Centre idle: sides arbitrate by arrival
// (RULE6) Left/right priority similar; others by arrival
// (RULE7) Reject second merge zone on module
// (RULE8) Refuse activation with extension zone attached
// (RULE9) Merge zone only in accumulation mode
// (RULE10) Feeder may serve only one merge
// (RULE11) External controller honours zone status
// (RULE12) Discharge zone must be directly downstream
// (RULE13) Feeder must be line's last zone
// (RULE14) Merge on upstream, downstream or single
// (RULE15) Single-zone module zone is logically upstream
// (RULE16) Left, right or both, spur or perpendicular
// (RULE17) Same-cycle arrival tie: centre, left, right
// (RULE18) One grant held until item enters merge zone
module cmr_arbiter (
    input  wire logic              CLK_SYS,
    input  wire logic              SRST,
    input  cmr_pkg::cmr_cfg_s      CFG,
    input  wire logic [2:0]        ARRIVED,
    input  wire logic              MERGE_CLEAR,
    output logic [2:0]             RELEASE,
    output logic                   ACTIVE,
    output logic                   CFG_ERR,
    output logic                   MERGE_ZONE_DOWN
);

    // =====================================================================
    // State
    // =====================================================================
    cmr_pkg::cmr_state_s r;        // Registered state
    cmr_pkg::cmr_state_s next_r;   // Next state
    logic [2:0] en;                // Feeders configured present
    logic [2:0] wait_v;            // Feeders with an item waiting
    logic [2:0] fav;               // Favoured line one-hot
    logic [2:0] pick;              // Chosen feeder

    // Present lines; both sides may be spur or perpendicular alike
    assign en = {CFG.right_en, CFG.left_en, 1'b1}; // RULE16
    assign wait_v = ARRIVED & en;

    // Favoured line from priority mode
    always_comb begin
        case (CFG.pri)
            cmr_pkg::CMR_PRI_CENTRE: fav = 3'h1;
            cmr_pkg::CMR_PRI_LEFT:   fav = 3'h2;
            cmr_pkg::CMR_PRI_RIGHT:  fav = 3'h4;
            default:                 fav = 3'h0;
        endcase
    end

    // Oldest waiting feeder; strict greater keeps lower index on ties
    function automatic logic [2:0] oldest(input logic [2:0] m,
                                          input logic [2:0][cmr_pkg::AGE_W-1:0] a);
        logic [2:0] res;
        logic [cmr_pkg::AGE_W-1:0] best;
        res = 3'h0;
        best = '0;
        for (int i = 0; i < 3; i++) begin
            if (m[i] && (res == 3'h0 || a[i] > best)) begin // RULE17
                res = 3'h0;
                res[i] = 1'b1;
                best = a[i];
            end
        end
        return res;
    endfunction

    // Selection: favoured line first, rest by arrival order
    always_comb begin
        if ((wait_v & fav) != 3'h0) begin
            pick = wait_v & fav; // RULE3 RULE6
        end else begin
            pick = oldest(wait_v & ~fav, r.age); // RULE1 RULE4 RULE5 RULE6
        end
    end

    // =====================================================================
    // Next-state logic
    // =====================================================================
    always_comb begin
        next_r = r;
        // Configuration checks gate activation
        next_r.cfg_err = CFG.merge_count_bad            // RULE7
                       | CFG.has_extension              // RULE8
                       | (CFG.merge_mode != cmr_pkg::CMR_ZONE_ACCUM) // RULE9
                       | CFG.feeder_shared              // RULE10
                       | ~CFG.discharge_adj             // RULE12
                       | ((CFG.feeder_last & en) != en) // RULE13
                       | ~(CFG.left_en | CFG.right_en); // RULE16
        // Single-zone module always reports upstream placement
        next_r.zone_down = CFG.single_zone ? 1'b0 : CFG.merge_on_down; // RULE14 RULE15
        // Age counters: arrival order is remembered per feeder
        for (int i = 0; i < 3; i++) begin
            if (!wait_v[i]) begin
                next_r.age[i] = cmr_pkg::AGE_RST;
            end else if (r.age[i] != cmr_pkg::AGE_MAX) begin
                next_r.age[i] = r.age[i] + 4'h1;
            end
        end
        case (r.st)
            cmr_pkg::CMR_ST_OFF: begin
                next_r.grant = 3'h0;
                if (!r.cfg_err) begin
                    next_r.st = cmr_pkg::CMR_ST_IDLE;
                end
            end
            cmr_pkg::CMR_ST_IDLE: begin
                if (r.cfg_err) begin
                    next_r.st = cmr_pkg::CMR_ST_OFF;
                end else if (MERGE_CLEAR && pick != 3'h0) begin
                    next_r.grant = pick; // RULE2
                    next_r.st = cmr_pkg::CMR_ST_GRANT;
                end
            end
            cmr_pkg::CMR_ST_GRANT: begin
                // Hold the grant until the item has entered the merge zone
                if (r.cfg_err) begin
                    next_r.grant = 3'h0;
                    next_r.st = cmr_pkg::CMR_ST_OFF;
                end else if (!MERGE_CLEAR) begin
                    next_r.grant = 3'h0; // RULE18
                    next_r.st = cmr_pkg::CMR_ST_IDLE;
                end
            end
            default: begin
                next_r.st = cmr_pkg::CMR_ST_OFF;
                next_r.grant = 3'h0;
            end
        endcase
        next_r.active = (next_r.st != cmr_pkg::CMR_ST_OFF);
        // Lines waiting this cycle; the checks tie every grant to an arrival
        next_r.seen = wait_v;
    end

    // =====================================================================
    // Registers
    // =====================================================================
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            r.st <= cmr_pkg::CMR_ST_OFF;
            r.grant <= cmr_pkg::GRANT_RST;
            r.seen <= 3'h0;
            r.age <= '0;
            r.active <= 1'b0;
            r.cfg_err <= 1'b1;
            r.zone_down <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign RELEASE = r.grant;
    assign ACTIVE = r.active;
    assign CFG_ERR = r.cfg_err;
    assign MERGE_ZONE_DOWN = r.zone_down;

    // =====================================================================
    // Checks
    // =====================================================================
    one_grant_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE18
        $onehot0(RELEASE)) else $error("more than one release");
    err_blocks_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE8
        CFG.has_extension |=> ##1 (RELEASE == 3'h0)) else $error("release with extension");
    mode_chk_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE9
        (CFG.merge_mode != cmr_pkg::CMR_ZONE_ACCUM) |=> CFG_ERR) else $error("bad mode accepted");
    dual_merge_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE7
        CFG.merge_count_bad |=> CFG_ERR) else $error("second merge accepted");
    single_up_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE15
        CFG.single_zone |=> !MERGE_ZONE_DOWN) else $error("single zone not upstream");
    grant_clear_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE2
        $rose(|RELEASE) |-> $past(MERGE_CLEAR)) else $error("release while occupied");
    centre_first_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE3
        (r.st == cmr_pkg::CMR_ST_IDLE && !r.cfg_err && MERGE_CLEAR && !CFG.has_extension
         && CFG.pri == cmr_pkg::CMR_PRI_CENTRE && ARRIVED[0]) |=> RELEASE[0])
        else $error("centre not favoured");
    shared_feed_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE10
        CFG.feeder_shared |=> CFG_ERR) else $error("shared feeder accepted");
    // Discharge zone not adjacent must be refused
    discharge_adj_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE12
        !CFG.discharge_adj |=> CFG_ERR)
        else $error("non-adjacent discharge accepted");
    // Left feeder that is not its line's last zone
    feeder_last_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE13
        (CFG.left_en && !CFG.feeder_last[1]) |=> CFG_ERR)
        else $error("feeder not last zone accepted");
    // A merge with no side line is no merge at all
    no_side_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE16
        !(CFG.left_en || CFG.right_en) |=> CFG_ERR)
        else $error("merge without side line accepted");
    // A disabled right line never gets a release
    right_enabled_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE16
        $rose(RELEASE[2]) |-> $past(CFG.right_en))
        else $error("release to disabled right line");
    // Refused configuration drops the block out of service
    err_idle_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE8
        CFG_ERR |=> !ACTIVE)
        else $error("active with bad configuration");
    // Out of service means no release at all
    off_quiet_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE8
        !ACTIVE |-> (RELEASE == 3'h0))
        else $error("release while inactive");
    // Grant stands until the item is seen in the merge zone
    hold_grant_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE18
        (RELEASE != 3'h0 && MERGE_CLEAR && !CFG_ERR) |=> (RELEASE == $past(RELEASE)))
        else $error("grant dropped early");
    // Only a line that was waiting may be released
    granted_waiting_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE1
        $rose(|RELEASE) |-> ((RELEASE & ~r.seen) == 3'h0))
        else $error("release to idle line");
    // Equal arrival in arrival-order mode goes to the centre
    fcfs_tie_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE17
        (r.st == cmr_pkg::CMR_ST_IDLE && !r.cfg_err && MERGE_CLEAR && CFG.pri == cmr_pkg::CMR_PRI_FCFS
         && CFG.left_en && CFG.right_en && ARRIVED == 3'h7
         && r.age[0] == r.age[1] && r.age[1] == r.age[2]) |=> (RELEASE == 3'h1))
        else $error("tie not given to centre");
    // Placement follows the configuration on a two-zone module
    zone_track_a: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE14
        !CFG.single_zone |=> (MERGE_ZONE_DOWN == $past(CFG.merge_on_down)))
        else $error("merge placement not reported");

endmodule

// *** core/cmr_pkg.sv ***
package cmr_pkg;

    // =====================================================================
    // Feeder lines and priority modes
    // =====================================================================
    localparam int unsigned NUM_FEED = 3;          // Centre, left, right
    localparam int unsigned FEED_CENTRE = 0;       // Index of centre feeder
    localparam int unsigned FEED_LEFT = 1;         // Index of left feeder
    localparam int unsigned FEED_RIGHT = 2;        // Index of right feeder
    localparam int unsigned AGE_W = 4;             // Arrival age counter width
    localparam logic [3:0] AGE_MAX = 4'hf;         // Saturated age
    localparam logic [3:0] AGE_RST = 4'h0;         // Age after reset
    localparam logic [2:0] GRANT_RST = 3'h0;       // No grant after reset

    // Priority selection: 0 arrival order, 1 centre, 2 left, 3 right
    typedef enum logic [1:0] {
        CMR_PRI_FCFS,
        CMR_PRI_CENTRE,
        CMR_PRI_LEFT,
        CMR_PRI_RIGHT
    } cmr_pri_e;

    // Zone operating mode of a zone
    typedef enum logic {
        CMR_ZONE_ACCUM,                            // zone_accumulation_mode
        CMR_ZONE_EXTIO                             // external_controller_io_mode
    } cmr_zmode_e;

    // Arbiter state
    typedef enum logic [1:0] {
        CMR_ST_OFF,
        CMR_ST_IDLE,
        CMR_ST_GRANT
    } cmr_st_e;

    // Configuration carried as one bundle
    typedef struct packed {
        cmr_pri_e   pri;              // Priority mode
        logic       left_en;          // Left line present
        logic       right_en;         // Right line present
        logic       left_tmerge;      // Left is perpendicular discharge
        logic       right_tmerge;     // Right is perpendicular discharge
        cmr_zmode_e merge_mode;       // Mode of the merge zone
        logic       merge_count_bad;  // Second merge zone requested on module
        logic       has_extension;    // Slaved extension on merge zone
        logic       feeder_shared;    // A feeder also feeds another merge
        logic       discharge_adj;    // Discharge zone directly downstream
        logic [2:0] feeder_last;      // Each feeder is its line's last zone
        logic       single_zone;      // Module configured for one zone
        logic       merge_on_down;    // Merge assigned to downstream zone
    } cmr_cfg_s;

    // Registered state of the block
    typedef struct packed {
        cmr_st_e    st;
        logic [2:0] grant;
        logic [2:0] seen;
        logic [2:0][AGE_W-1:0] age;
        logic       active;
        logic       cfg_err;
        logic       zone_down;
    } cmr_state_s;

endpackage

// *** tb/cmr_zone_model.sv ***
`timescale 1ns/10ps
// ====
// Merge zone occupancy model
// ====
module cmr_zone_model (
    input  wire logic       CLK_SYS,
    input  wire logic       SRST,
    input  wire logic [2:0] RELEASE,    // Grant from the arbiter
    input  wire logic [3:0] DLY,        // Cycles to enter and to clear, less one (each phase lasts DLY+1)
    output logic            MERGE_CLEAR // Merge zone sensor clear
);
    logic [3:0] cnt; // Cycles in current phase

    // Item enters only on a grant, so releases stay singulated
    always @(negedge CLK_SYS) begin
        if (SRST) begin
            MERGE_CLEAR <= 1'b1;
            cnt         <= 4'h0;
        end else if (!MERGE_CLEAR || RELEASE != 3'h0) begin
            cnt <= (cnt == DLY) ? 4'h0 : cnt + 4'h1;
            if (cnt == DLY) begin
                MERGE_CLEAR <= !MERGE_CLEAR;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
    logic               clk_sys;
    logic               srst;
    cmr_pkg::cmr_cfg_s  cfg;
    logic [2:0]         arr;
    logic [3:0]         dly;
    logic               clr;
    logic [2:0]         rel;
    logic               act;
    logic               err;
    logic               zdn;
    int                 error_cnt;
    int                 samples_checked;
    // Grant order per mode, first grant in the top three bits
    logic [8:0]         seq [4] = '{9'h054, 9'h054, 9'h08c, 9'h10a};

    cmr_arbiter i_dut (.CLK_SYS(clk_sys), .SRST(srst), .CFG(cfg), .ARRIVED(arr), .MERGE_CLEAR(clr),
                       .RELEASE(rel), .ACTIVE(act), .CFG_ERR(err), .MERGE_ZONE_DOWN(zdn));
    cmr_zone_model i_zone (.CLK_SYS(clk_sys), .SRST(srst), .RELEASE(rel), .DLY(dly), .MERGE_CLEAR(clr));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait step; a hang ends the run
    task automatic tick(inout int n);
        @(negedge clk_sys);
        n++;
        if (n > 60) begin
            error_cnt++;
            end_sim();
        end
    endtask

    // Valid merge with both side lines
    task automatic good();
        cfg = '0;
        cfg.left_en = 1'b1;
        cfg.right_en = 1'b1;
        cfg.discharge_adj = 1'b1;
        cfg.feeder_last = 3'h7;
        cfg.merge_on_down = 1'b1;
    endtask

    // One release: wait for grant, retire its item, add new arrivals
    task automatic go(input logic [2:0] e, input logic [2:0] a1, input logic [2:0] a2);
        int n;
        n = 0;
        while (rel === 3'h0) tick(n);
        `CHK("release", e, rel)
        arr = (arr & ~e) | a1;
        @(negedge clk_sys);
        arr = arr | a2;
        if (dly > 4'h2) `CHK("hold", e, rel)
        // Stop as soon as the grant drops, so a prompt next grant is not missed
        while (rel !== 3'h0) tick(n);
    endtask

    // Main sequence
    initial begin
        srst = 1'b1;
        arr = 3'h0;
        dly = 4'h3;
        error_cnt = 0;
        samples_checked = 0;
        good();
        repeat (2) @(negedge clk_sys);
        `CHK("rst_rel", 3'h0, rel)
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK("active", 1'b1, act)
        `CHK("zone_down", 1'b1, zdn)
        // Staggered arrivals in arrival order
        arr = 3'h2;
        go(3'h2, 3'h4, 3'h1);
        go(3'h4, 3'h0, 3'h0);
        go(3'h1, 3'h0, 3'h0);
        // Centre favoured even when it arrives last
        cfg.pri = cmr_pkg::CMR_PRI_CENTRE;
        arr = 3'h2;
        go(3'h2, 3'h4, 3'h1);
        go(3'h1, 3'h0, 3'h1);
        go(3'h1, 3'h0, 3'h2);
        go(3'h4, 3'h0, 3'h0);
        go(3'h2, 3'h0, 3'h0);
        // Every mode, all lines at once, prompt zone
        dly = 4'h0;
        for (int m = 0; m < 4; m++) begin
            cfg.pri = cmr_pkg::cmr_pri_e'(m);
            arr = 3'h7;
            for (int j = 2; j >= 0; j--) go(seq[m][j*3 +: 3], 3'h0, 3'h0);
        end
        // Left line only, perpendicular discharge
        cfg.pri = cmr_pkg::CMR_PRI_FCFS;
        cfg.right_en = 1'b0;
        cfg.left_tmerge = 1'b1;
        arr = 3'h4;
        repeat (4) @(negedge clk_sys);
        `CHK("no_right", 3'h0, rel)
        arr = 3'h6;
        go(3'h2, 3'h0, 3'h0);
        arr = 3'h0;
        // Single-zone module reads as upstream
        good();
        cfg.single_zone = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("single_down", 1'b0, zdn)
        `CHK("single_ok", 1'b0, err)
        // Each faulty configuration is refused
        for (int k = 0; k < 7; k++) begin
            good();
            case (k)
                0: cfg.merge_count_bad = 1'b1;
                1: cfg.has_extension = 1'b1;
                2: cfg.merge_mode = cmr_pkg::CMR_ZONE_EXTIO;
                3: cfg.feeder_shared = 1'b1;
                4: cfg.discharge_adj = 1'b0;
                5: cfg.feeder_last = 3'h5;
                default: {cfg.left_en, cfg.right_en} = 2'h0;
            endcase
            repeat (3) @(negedge clk_sys);
            `CHK("cfg_err", 1'b1, err)
            arr = 3'h1;
            repeat (3) @(negedge clk_sys);
            `CHK("refused", 3'h0, rel)
            `CHK("inactive", 1'b0, act)
            arr = 3'h0;
        end
        end_sim();
    end
endmodule
